// [logic/cpu_decode_pkg.sv]
/*
 * Shared constants and types for the move, bit and branch decoder.
 * Assumes one core clock and an 8-bit accumulator datapath outside.
 */
// Operation
// - external memory: accumulator only, pointer addressing
// - table lookup reads code, base plus accumulator
// - bit space: 128 RAM bits plus registers
// - bank register to/from accumulator: 1/1
// - direct or immediate into accumulator: 2/2
// - pointer RAM into accumulator: 1/2
// - direct to bank 2/3, immediate 2/2
// - direct or immediate to direct: 3/3
// - load data pointer immediate: 3/3
// - code read: pointer 5, program counter 4
// - external read 4/3, write 5/4, one byte
// - into pointer RAM: 1/2, 2/3, 2/2
// - push 2/3, pop 2/2
// - exchange bank 2, others 3 cycles
// - bit move/set/clear/toggle/or/and plus jumps
// - carry and/or/move with bit: 2/2
// - write bit ops 2/3, carry-only 1/1
// - jump on carry: 2/3
// - bit jumps 3/5, jump-clear clears bit
// - short jump 2/3, indirect jump 1/5
// - accumulator zero jumps: 2/4
// - compare jump: 3 bytes, 5 or 4
// - decrement jump: bank 2/4, direct 3/5
// - pointer register zero/one, or data pointer
package cpu_decode_pkg;

    localparam int LEN_W = 2;
    localparam int CYC_W = 3;

    localparam logic [LEN_W-1:0] LEN1 = 2'h1;
    localparam logic [LEN_W-1:0] LEN2 = 2'h2;
    localparam logic [LEN_W-1:0] LEN3 = 2'h3;

    localparam logic [CYC_W-1:0] CYC1 = 3'h1;
    localparam logic [CYC_W-1:0] CYC2 = 3'h2;
    localparam logic [CYC_W-1:0] CYC3 = 3'h3;
    localparam logic [CYC_W-1:0] CYC4 = 3'h4;
    localparam logic [CYC_W-1:0] CYC5 = 3'h5;

    localparam logic [15:0] PC_RESET    = 16'h0000;
    localparam int          BIT_RAM_NUM = 128;

    typedef enum logic [3:0] {
        ClsNone,
        ClsMove,
        ClsExt,
        ClsCode,
        ClsStack,
        ClsXchg,
        ClsBit,
        ClsBranch,
        ClsIllegal
    } op_class_t;

    typedef enum logic [2:0] {
        BitNone,
        BitMove,
        BitSet,
        BitClr,
        BitCpl,
        BitOr,
        BitAnd,
        BitJump
    } bit_op_t;

endpackage

// [logic/cycle_timer.sv]
/*
 * Holds an instruction busy for its cycle count and pulses done.
 * Assumes load only while busy_q is low; count is at least one.
 */
`timescale 1ns/1ps
module cycle_timer #(
    parameter int CW = 3
) (
    input  wire logic          clk,
    input  wire logic          rstN,
    input  wire logic          load,
    input  wire logic [CW-1:0] count,
    output logic               busy_q,
    output logic               done_q
);
    logic [CW-1:0] rem_q;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rem_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (load) begin
                if (count == CW'(1)) begin
                    done_q <= 1'b1;
                end else begin
                    rem_q  <= count - CW'(1);
                    busy_q <= 1'b1;
                end
            end else if (busy_q) begin
                if (rem_q == CW'(1)) begin
                    done_q <= 1'b1;
                    busy_q <= 1'b0;
                end else begin
                    rem_q <= rem_q - CW'(1);
                end
            end
        end
    end
endmodule

// [logic/bit_addr_map.sv]
/*
 * Maps an 8-bit bit address to its byte and bit position.
 * Assumes the RAM bit area starts on a 16-byte boundary.
 */
`timescale 1ns/1ps
module bit_addr_map #(
    parameter logic [7:0] RAM_BASE = 8'h20
) (
    input  wire logic [7:0] bitAddr,
    output logic      [7:0] byteAddr,
    output logic      [2:0] bitPos,
    output logic            inSfr
);
    // low half: the 128 RAM bits; high half: register bits
    always_comb begin
        inSfr  = bitAddr[7];
        bitPos = bitAddr[2:0];
        if (bitAddr[7]) begin
            byteAddr = {bitAddr[7:3], 3'h0};
        end else begin
            byteAddr = RAM_BASE + {4'h0, bitAddr[6:3]};
        end
    end
endmodule

// [logic/cpu_move_bit_branch.sv]
/*
 * Decoder and timing for move, bit and branch instructions.
 * Assumes operand bytes and operand values are valid with issue.
 */
`timescale 1ns/1ps
module cpu_move_bit_branch
    import cpu_decode_pkg::*;
#(
    parameter logic [7:0] RAM_BASE = 8'h20
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        issue,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  operand1,
    input  wire logic [7:0]  operand2,
    input  wire logic [7:0]  accIn,
    input  wire logic        carryIn,
    input  wire logic        bitIn,
    input  wire logic [7:0]  opndIn,
    input  wire logic [15:0] dptrIn,
    output logic [15:0]      pc_q,
    output logic             busy_q,
    output logic             done_q,
    output logic [LEN_W-1:0] instLen_q,
    output logic [CYC_W-1:0] instCycles_q,
    output op_class_t        opClass_q,
    output bit_op_t          bitOp_q,
    output logic             illegal_q,
    output logic             extRead_q,
    output logic             extWrite_q,
    output logic             extWide_q,
    output logic             ptrUse_q,
    output logic             ptrSel_q,
    output logic             codeRead_q,
    output logic [15:0]      codeAddr_q,
    output logic             bitValid_q,
    output logic [7:0]       bitByte_q,
    output logic [2:0]       bitPos_q,
    output logic             bitSfr_q,
    output logic             taken_q,
    output logic             bitClear_q
);
    logic [1:0] rstSync_q;
    logic       rstN;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstN = rstSync_q[1];

    logic             take;
    logic [LEN_W-1:0] len;
    logic [CYC_W-1:0] cyc;
    op_class_t        cls;
    bit_op_t          bop;
    logic             extR;
    logic             extW;
    logic             extWide;
    logic             usePtr;
    logic             codeRd;
    logic             codeDptr;
    logic             hasBit;
    logic             jmpInd;
    logic             takenD;
    logic             clrBit;
    logic [7:0]       relB;
    logic [15:0]      pcSeq;
    logic [15:0]      pcNext;
    logic [15:0]      codeAddr;
    logic [7:0]       mapByte;
    logic [2:0]       mapPos;
    logic             mapSfr;

    assign take = issue && !busy_q;

    always_comb begin
        len      = LEN1;
        cyc      = CYC1;
        cls      = ClsMove;
        bop      = BitNone;
        extR     = 1'b0;
        extW     = 1'b0;
        extWide  = 1'b0;
        usePtr   = 1'b0;
        codeRd   = 1'b0;
        codeDptr = 1'b0;
        hasBit   = 1'b0;
        jmpInd   = 1'b0;
        takenD   = 1'b0;
        clrBit   = 1'b0;
        unique casez (opcode)
            8'b1110_1???, 8'b1111_1???: begin
                cyc = CYC1;
            end
            8'he5, 8'h74: begin
                len = LEN2;
                cyc = CYC2;
            end
            8'b1110_011?: begin
                cyc    = CYC2;
                usePtr = 1'b1;
            end
            8'b1010_1???: begin
                len = LEN2;
                cyc = CYC3;
            end
            8'b0111_1???, 8'hf5, 8'b1000_1???: begin
                len = LEN2;
                cyc = CYC2;
            end
            8'h85, 8'h75, 8'h90: begin
                len = LEN3;
                cyc = CYC3;
            end
            8'b1000_011?, 8'b1010_011?: begin
                len    = LEN2;
                cyc    = CYC3;
                usePtr = 1'b1;
            end
            8'b1111_011?: begin
                cyc    = CYC2;
                usePtr = 1'b1;
            end
            8'b0111_011?: begin
                len    = LEN2;
                cyc    = CYC2;
                usePtr = 1'b1;
            end
            8'h93, 8'h83: begin
                cls      = ClsCode;
                codeRd   = 1'b1;
                codeDptr = opcode[4];
                cyc      = opcode[4] ? CYC5 : CYC4;
            end
            8'b1110_001?, 8'he0, 8'b1111_001?, 8'hf0: begin
                cls     = ClsExt;
                extR    = !opcode[4];
                extW    = opcode[4];
                extWide = !opcode[1];
                usePtr  = opcode[1];
                unique case ({opcode[4], opcode[1]})
                    2'b01:   cyc = CYC4;
                    2'b00:   cyc = CYC3;
                    2'b11:   cyc = CYC5;
                    default: cyc = CYC4;
                endcase
            end
            8'hc0, 8'hd0: begin
                cls = ClsStack;
                len = LEN2;
                cyc = opcode[4] ? CYC2 : CYC3;
            end
            8'b1100_1???: begin
                cls = ClsXchg;
                cyc = CYC2;
            end
            8'hc5: begin
                cls = ClsXchg;
                len = LEN2;
                cyc = CYC3;
            end
            8'b1100_011?, 8'b1101_011?: begin
                cls    = ClsXchg;
                cyc    = CYC3;
                usePtr = 1'b1;
            end
            8'hc3, 8'hd3, 8'hb3: begin
                cls = ClsBit;
                cyc = CYC1;
                bop = opcode[4] ? (opcode[6] ? BitSet : BitCpl) : BitClr;
            end
            8'hc2, 8'hd2, 8'hb2, 8'h92: begin
                cls    = ClsBit;
                len    = LEN2;
                cyc    = CYC3;
                hasBit = 1'b1;
                unique case (opcode[7:4])
                    4'hc:    bop = BitClr;
                    4'hd:    bop = BitSet;
                    4'hb:    bop = BitCpl;
                    default: bop = BitMove;
                endcase
            end
            8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2: begin
                cls    = ClsBit;
                len    = LEN2;
                cyc    = CYC2;
                hasBit = 1'b1;
                unique case (opcode)
                    8'h82, 8'hb0: bop = BitAnd;
                    8'h72, 8'ha0: bop = BitOr;
                    default:      bop = BitMove;
                endcase
            end
            8'h40, 8'h50: begin
                cls    = ClsBranch;
                bop    = BitJump;
                len    = LEN2;
                cyc    = CYC3;
                takenD = carryIn ^ opcode[4];
            end
            8'h20, 8'h30, 8'h10: begin
                cls    = ClsBranch;
                bop    = BitJump;
                len    = LEN3;
                cyc    = CYC5;
                hasBit = 1'b1;
                takenD = bitIn ^ (opcode[5:4] == 2'h3);
                clrBit = (opcode == 8'h10) && bitIn;
            end
            8'h80: begin
                cls    = ClsBranch;
                len    = LEN2;
                cyc    = CYC3;
                takenD = 1'b1;
            end
            8'h73: begin
                cls    = ClsBranch;
                cyc    = CYC5;
                jmpInd = 1'b1;
            end
            8'h60, 8'h70: begin
                cls    = ClsBranch;
                len    = LEN2;
                cyc    = CYC4;
                takenD = (accIn == 8'h00) ^ opcode[4];
            end
            8'hb5, 8'b1011_011?: begin
                cls    = ClsBranch;
                len    = LEN3;
                cyc    = CYC5;
                usePtr = opcode[1];
                takenD = opcode[1] ? (opndIn != operand1)
                                   : (accIn != opndIn);
            end
            8'hb4, 8'b1011_1???: begin
                cls    = ClsBranch;
                len    = LEN3;
                cyc    = CYC4;
                takenD = opcode[3] ? (opndIn != operand1)
                                   : (accIn != operand1);
            end
            8'b1101_1???: begin
                cls    = ClsBranch;
                len    = LEN2;
                cyc    = CYC4;
                takenD = opndIn != 8'h01;
            end
            8'hd5: begin
                cls    = ClsBranch;
                len    = LEN3;
                cyc    = CYC5;
                takenD = opndIn != 8'h01;
            end
            8'h00: begin
                cls = ClsNone;
            end
            default: begin
                cls = ClsIllegal;
            end
        endcase
    end

    assign relB   = (len == LEN3) ? operand2 : operand1;
    assign pcSeq  = pc_q + {14'h0, len};
    assign pcNext = jmpInd ? dptrIn + {8'h00, accIn}
                  : takenD ? pcSeq + {{8{relB[7]}}, relB}
                  : pcSeq;
    // code reads index from data pointer or the next instruction
    assign codeAddr = (codeDptr ? dptrIn : pcSeq) + {8'h00, accIn};

    bit_addr_map #(
        .RAM_BASE (RAM_BASE)
    ) u_map (
        .bitAddr  (operand1),
        .byteAddr (mapByte),
        .bitPos   (mapPos),
        .inSfr    (mapSfr)
    );

    cycle_timer #(
        .CW (CYC_W)
    ) u_timer (
        .clk    (ref_clk),
        .rstN   (rstN),
        .load   (take),
        .count  (cyc),
        .busy_q (busy_q),
        .done_q (done_q)
    );

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            pc_q <= PC_RESET;
        end else if (take) begin
            pc_q <= pcNext;
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            instLen_q    <= LEN1;
            instCycles_q <= CYC1;
            opClass_q    <= ClsNone;
            bitOp_q      <= BitNone;
            illegal_q    <= 1'b0;
            taken_q      <= 1'b0;
        end else if (take) begin
            instLen_q    <= len;
            instCycles_q <= cyc;
            opClass_q    <= cls;
            bitOp_q      <= bop;
            illegal_q    <= cls == ClsIllegal;
            taken_q      <= takenD || jmpInd;
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            extRead_q  <= 1'b0;
            extWrite_q <= 1'b0;
            extWide_q  <= 1'b0;
            ptrUse_q   <= 1'b0;
            ptrSel_q   <= 1'b0;
            codeRead_q <= 1'b0;
            codeAddr_q <= 16'h0000;
        end else if (take) begin
            extRead_q  <= extR;
            extWrite_q <= extW;
            extWide_q  <= extWide;
            ptrUse_q   <= usePtr;
            ptrSel_q   <= usePtr && opcode[0];
            codeRead_q <= codeRd;
            codeAddr_q <= codeAddr;
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            bitValid_q <= 1'b0;
            bitByte_q  <= 8'h00;
            bitPos_q   <= 3'h0;
            bitSfr_q   <= 1'b0;
            bitClear_q <= 1'b0;
        end else begin
            bitClear_q <= take && clrBit;
            if (take) begin
                bitValid_q <= hasBit;
                bitByte_q  <= mapByte;
                bitPos_q   <= mapPos;
                bitSfr_q   <= mapSfr;
            end
        end
    end

    // checking helpers: cycles since the last accepted instruction, counted up to the cycle busy_q drops
    logic [CYC_W-1:0] elapsed_q;

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            elapsed_q <= '0;
        end else if (take) begin
            elapsed_q <= CYC1;
        end else if (busy_q) begin
            elapsed_q <= elapsed_q + CYC1;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstN);

    property lc(logic hit, logic [LEN_W-1:0] l, logic [CYC_W-1:0] c);
        hit |=> instLen_q == l && instCycles_q == c;
    endproperty

    done_timing_a: assert property (
        done_q |-> elapsed_q == instCycles_q)
        else $error("done not at listed cycle count");
    pc_advance_a: assert property (
        take && opcode == 8'h90 |=> pc_q == $past(pc_q) + 16'h0003)
        else $error("pc not advanced by length");
    ext_only_acc_a: assert property (
        extRead_q || extWrite_q |-> opClass_q == ClsExt
                                    && instLen_q == LEN1)
        else $error("external access outside external class");
    code_index_a: assert property (
        take && opcode == 8'h93 |=> codeRead_q
            && codeAddr_q == $past(dptrIn) + {8'h00, $past(accIn)})
        else $error("code lookup address wrong");
    bit_space_a: assert property (
        bitValid_q && !bitSfr_q |-> bitByte_q[7:4] == RAM_BASE[7:4])
        else $error("ram bit outside bit area");
    bank_move_a: assert property (
        lc(take && opcode[7:3] == 5'h1d, LEN1, CYC1))
        else $error("bank move timing wrong");
    acc_load_a: assert property (
        lc(take && opcode == 8'h74, LEN2, CYC2))
        else $error("immediate load timing wrong");
    ptr_load_a: assert property (
        lc(take && opcode == 8'he6, LEN1, CYC2))
        else $error("pointer load timing wrong");
    bank_direct_a: assert property (
        lc(take && opcode[7:3] == 5'h15, LEN2, CYC3))
        else $error("direct to bank timing wrong");
    dir_dir_a: assert property (
        lc(take && opcode == 8'h85, LEN3, CYC3))
        else $error("direct copy timing wrong");
    data_pointer_load_a: assert property (
        lc(take && opcode == 8'h90, LEN3, CYC3))
        else $error("pointer load timing wrong");
    code_pc_a: assert property (
        lc(take && opcode == 8'h83, LEN1, CYC4))
        else $error("pc lookup timing wrong");
    ext_write_a: assert property (
        take && opcode == 8'hf2 |=> extWrite_q && instCycles_q == CYC5
            ##4 done_q)
        else $error("external write timing wrong");
    ptr_store_a: assert property (
        lc(take && opcode[7:1] == 7'h53, LEN2, CYC3))
        else $error("direct to pointer ram timing wrong");
    stack_a: assert property (
        lc(take && opcode == 8'hd0, LEN2, CYC2))
        else $error("pop timing wrong");
    exchange_a: assert property (
        lc(take && opcode[7:1] == 7'h6b, LEN1, CYC3))
        else $error("nibble exchange timing wrong");
    bit_kind_a: assert property (
        take && opcode == 8'hb2 |=> bitOp_q == BitCpl && bitValid_q)
        else $error("bit toggle not decoded");
    carry_and_a: assert property (
        lc(take && opcode == 8'hb0, LEN2, CYC2))
        else $error("carry and timing wrong");
    carry_only_a: assert property (
        lc(take && opcode == 8'hd3, LEN1, CYC1))
        else $error("carry set timing wrong");
    carry_jump_a: assert property (
        take && opcode == 8'h40 |=> taken_q == $past(carryIn))
        else $error("carry jump decision wrong");
    jump_clear_a: assert property (
        take && opcode == 8'h10 && bitIn |=> bitClear_q && taken_q
            ##1 !bitClear_q)
        else $error("jump clear did not clear once");
    ind_jump_a: assert property (
        take && opcode == 8'h73 |=>
            pc_q == $past(dptrIn) + {8'h00, $past(accIn)})
        else $error("indirect jump target wrong");
    acc_zero_a: assert property (
        lc(take && opcode == 8'h60, LEN2, CYC4))
        else $error("zero jump timing wrong");
    compare_a: assert property (
        lc(take && opcode[7:3] == 5'h17, LEN3, CYC4))
        else $error("compare jump timing wrong");
    dec_jump_a: assert property (
        lc(take && opcode == 8'hd5, LEN3, CYC5))
        else $error("decrement jump timing wrong");
    ptr_select_a: assert property (
        take && opcode == 8'he3 |=> ptrSel_q && !extWide_q)
        else $error("pointer register select wrong");

    jbc_taken_c: cover property (take && opcode == 8'h10 ##1 bitClear_q);
    long_wait_c: cover property (take && cyc == CYC5 ##5 done_q);
    back_back_c: cover property (take ##1 take);
    ext_read_c: cover property (take && opcode == 8'he0 ##1 extRead_q);
endmodule

// [verif/data_mem_model.sv]
/*
 * Internal data memory seen through the operand address byte.
 * Assumes the core reads operand values combinationally with issue.
 */
`timescale 1ns/1ps
module data_mem_model (
    input  wire logic [7:0] addr,
    output logic      [7:0] rdData,
    output logic            rdBit
);
    logic [7:0] mem [256];

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i * 37 + 11);
        end
    end

    assign rdData = mem[addr];
    assign rdBit  = ^mem[addr];
endmodule

// [verif/testbench.sv]
/*
 * Self-checking bench for the move, bit and branch decoder.
 * Assumes the data memory model answers operand reads at once.
 */
`timescale 1ns/1ps
module testbench;
    import cpu_decode_pkg::*;
    logic             ref_clk = 1'b0;
    logic             resetn = 1'b0;
    logic             issue = 1'b0;
    logic             carryIn = 1'b0;
    logic [7:0]       opcode = 8'h00, operand1 = 8'h00;
    logic [7:0]       operand2 = 8'h00, accIn = 8'h00;
    logic [15:0]      dptrIn = 16'h0000;
    logic [7:0]       opndIn, bitByte_q, op, a, rel;
    logic [15:0]      pc_q, codeAddr_q, pcOld, expPc;
    logic [LEN_W-1:0] instLen_q;
    logic [CYC_W-1:0] instCycles_q;
    op_class_t        opClass_q;
    bit_op_t          bitOp_q;
    logic [2:0]       bitPos_q;
    logic             bitIn, busy_q, done_q, illegal_q, extRead_q, t, clr, bsy;
    logic             extWrite_q, extWide_q, ptrUse_q, ptrSel_q, codeRead_q;
    logic             bitValid_q, bitSfr_q, taken_q, bitClear_q;
    logic [31:0]      seed = 32'hf96039cb;
    int               failCount = 0, numChecks = 0, cycles = 0, n, len;
    // opcode, byte count, cycle count
    logic [15:0]      tbl [$] = {
        16'he811, 16'hf811, 16'he522, 16'h7422, 16'he612,
        16'ha823, 16'h7822, 16'h8533, 16'h7533, 16'h9033,
        16'h9315, 16'h8314, 16'he214, 16'he314, 16'he013,
        16'hf215, 16'hf014, 16'hf612, 16'ha623, 16'h7622,
        16'hc023, 16'hd022, 16'hc812, 16'hc523, 16'hc613,
        16'hd613, 16'hc311, 16'hc223, 16'hd311, 16'hd223,
        16'hb311, 16'hb223, 16'h9223, 16'h8222, 16'hb022,
        16'h7222, 16'ha022, 16'ha222, 16'h4023, 16'h5023,
        16'h2035, 16'h3035, 16'h1035, 16'h8023, 16'h7315,
        16'h6024, 16'h7024, 16'hb535, 16'hb434, 16'hb834,
        16'hb635, 16'hd824, 16'hd535, 16'h0011};
    logic [15:0]      bitOps [$] = {16'hc203, 16'hd202, 16'hb204, 16'h8206,
        16'hb006, 16'h7205, 16'ha005, 16'ha201, 16'h9201, 16'h1007};
    logic [7:0]       brOps [$] = {8'h80, 8'h40, 8'h50, 8'h60, 8'h70,
        8'h20, 8'h30, 8'h10, 8'hd8, 8'hb4, 8'hb5, 8'hb6, 8'hd5};
    logic [7:0]       badOps [$] = {8'h24, 8'h12, 8'h04, 8'ha4};

    cpu_move_bit_branch dut (.ref_clk, .resetn, .issue, .opcode, .operand1,
        .operand2, .accIn, .carryIn, .bitIn, .opndIn, .dptrIn, .pc_q, .busy_q,
        .done_q, .instLen_q, .instCycles_q, .opClass_q, .bitOp_q, .illegal_q,
        .extRead_q, .extWrite_q, .extWide_q, .ptrUse_q, .ptrSel_q,
        .codeRead_q, .codeAddr_q, .bitValid_q, .bitByte_q, .bitPos_q,
        .bitSfr_q, .taken_q, .bitClear_q);
    data_mem_model mem (.addr(operand1), .rdData(opndIn), .rdBit(bitIn));

    initial forever #12.5 ref_clk = ~ref_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        numChecks++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkCyc(input logic [15:0] g, input logic [15:0] e);
        chk(g, e);
    endtask
    task automatic chkLen(input logic [15:0] g, input logic [15:0] e);
        chk(g, e);
    endtask
    task automatic chkPc(input logic [15:0] g, input logic [15:0] e);
        chk(g, e);
    endtask
    task automatic chkAddr(input logic [15:0] g, input logic [15:0] e);
        chk(g, e);
    endtask
    task automatic chkDec(input logic [15:0] g, input logic [15:0] e);
        chk(g, e);
    endtask

    task automatic testDone;
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // drive one instruction, count cycles from take to done
    task automatic run(input logic [7:0] o, input logic [7:0] x,
                       input logic [7:0] y);
        @(posedge ref_clk);
        seed = lfsr(seed);
        pcOld = pc_q;
        issue <= 1'b1;
        opcode <= o;
        operand1 <= x;
        operand2 <= y;
        accIn <= seed[8] ? seed[7:0] : 8'h00;
        carryIn <= seed[9];
        dptrIn <= seed[31:16];
        @(posedge ref_clk);
        issue <= 1'b0;
        #1;
        clr = bitClear_q;
        bsy = busy_q;
        n = 1;
        while (done_q !== 1'b1 && n < 9) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failCount++;
            testDone();
        end
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chkPc(pc_q, PC_RESET);
        repeat (2) foreach (tbl[i]) begin
            op = tbl[i][15:8];
            run(op, 8'h00, 8'h00);
            expPc = pcOld + 16'(tbl[i][7:4]);
            if (op == 8'h73) expPc = dptrIn + 16'(accIn);
            chkCyc(16'(n), 16'(tbl[i][3:0]));
            chkCyc(16'(bsy), 16'(tbl[i][3:0] != 4'h1));
            chkLen(16'(instLen_q), 16'(tbl[i][7:4]));
            chkPc(pc_q, expPc);
            chkDec(16'({illegal_q, codeRead_q}),
                16'({1'b0, op == 8'h93 || op == 8'h83}));
            if (op == 8'h00) chkDec(16'(opClass_q), 16'(ClsNone));
            if (op == 8'h93)
                chkAddr(codeAddr_q, dptrIn + 16'(accIn));
            if (op == 8'h83)
                chkAddr(codeAddr_q, pcOld + 16'(accIn) + 16'h1);
            if (op[7:5] == 3'h7 && op[3:2] == 2'h0) begin
                chkDec(16'({extRead_q, extWrite_q, extWide_q}),
                    16'({~op[4], op[4], ~op[1]}));
                chkDec(16'({ptrUse_q, ptrSel_q}), 16'(op[1:0]));
            end
        end
        repeat (60) begin
            seed = lfsr(seed);
            op = brOps[seed[3:0] % 13];
            run(op, seed[15:8], seed[23:16]);
            len = (op[7:6] == 2'h0 && op[5:4] != 2'h0) ? 3 : 2;
            if (op inside {8'hb4, 8'hb5, 8'hb6, 8'hd5}) len = 3;
            case (op)
                8'h40: t = carryIn;
                8'h50: t = !carryIn;
                8'h60: t = accIn == 8'h00;
                8'h70: t = accIn != 8'h00;
                8'h20, 8'h10: t = bitIn;
                8'h30: t = !bitIn;
                8'hd8, 8'hd5: t = opndIn != 8'h01;
                8'hb4: t = accIn != operand1;
                8'hb5: t = accIn != opndIn;
                8'hb6: t = opndIn != operand1;
                default: t = 1'b1;
            endcase
            rel = len == 3 ? operand2 : operand1;
            expPc = pcOld + 16'(len) + (t ? {{8{rel[7]}}, rel} : 16'h0000);
            chkPc(pc_q, expPc);
            chkDec(16'(taken_q), 16'(t));
            chkDec(16'(clr), 16'(op == 8'h10 && bitIn));
        end
        repeat (3) foreach (bitOps[i]) begin
            seed = lfsr(seed);
            run(bitOps[i][15:8], seed[7:0], 8'h00);
            a = operand1;
            chkDec(16'(bitOp_q), 16'(bitOps[i][2:0]));
            chkAddr(16'({bitValid_q, bitSfr_q, bitPos_q, bitByte_q}),
                16'({1'b1, a[7], a[2:0],
                a[7] ? {a[7:3], 3'h0} : 8'h20 + 8'(a[6:3])}));
        end
        foreach (badOps[i]) begin
            run(badOps[i], 8'h00, 8'h00);
            chkCyc(16'(n), 16'h0001);
            chkPc(pc_q, pcOld + 16'h0001);
            chkDec(16'({illegal_q, opClass_q}),
                16'({1'b1, ClsIllegal}));
        end
        testDone();
    end
endmodule
